// >>> design/pcpa_xbar.sv
// priority crossbar decoder driving the port pins
`timescale 1ns/10ps
`include "pcpa_consts.svh"
// Function
// R01: each resource gets lowest free unskipped pin
// R02: serial port considered first
// R03: fixed priority order after the serial port
// R04: serial transmit/receive fixed on pins 4, 5
// R05: assigned pins passed over for later resources
// R06: skipped pins treated as already assigned
// R07: placement only on pins 0.0 to 2.3
// R08: pins 0.0 to 2.4 usable as gpio
// R09: special-function signals never placed by decoder
// R10: software skips pins used by analog functions
// R11: software skips gpio and bypassing digital pins
// R12: software skips reference, crystal, conversion pins
// R13: slave select placed only in four-wire mode
// R14: package pin set is a build parameter
// R15: software sets analog/digital mode per pin; the controller has no mode register for it
// R16: matrix enable bit turns crossbar on
// R17: disabled crossbar leaves pins as inputs
// R18: output drivers off while crossbar disabled
module pcpa_xbar #(
    parameter bit LARGE_PKG = 1'b1
) (
    input  wire logic        clock_i,
    input  wire logic        sys_rst_i,
    pcpa_if.dev              link,
    input  wire logic [16:0] periph_out_i,
    input  wire logic [16:0] periph_oe_i,
    output logic      [16:0] periph_in_o,
    input  wire logic [20:0] pin_in_i,
    output logic      [20:0] pin_out_o,
    output logic      [20:0] pin_oe_o
);
    // R14: crossbar and gpio pin counts follow the package
    localparam int XBAR_PINS = LARGE_PKG ? `PCPA_XBAR_LARGE : `PCPA_XBAR_SMALL;
    localparam int GPIO_PINS = LARGE_PKG ? `PCPA_PINS : `PCPA_GPIO_SMALL;

    logic [20:0]  meta_r;
    logic [20:0]  sync_r;
    logic [16:0]  res_en;
    logic [4:0]   place_idx [17];
    logic [16:0]  place_ok;
    logic [20:0]  used;
    logic [4:0]   idx_r [17];
    logic [16:0]  ok_r;
    logic [20:0]  claimed_r;
    logic         xbar_on;
    logic [20:0]  out_nxt;
    logic [20:0]  oe_nxt;
    logic [16:0]  in_nxt;

    // lowest free pin below the crossbar limit, msb flags success
    function automatic logic [5:0] first_free(input logic [20:0] busy);
        logic [5:0] res;
        res = 6'h00;
        for (int j = XBAR_PINS - 1; j >= 0; j--) begin
            if (!busy[j]) begin
                res = {1'b1, 5'(j)};
            end
        end
        return res;
    endfunction

    // pins come from outside, two flops before any use
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            meta_r <= 21'h000000;
            sync_r <= 21'h000000;
        end else begin
            meta_r <= pin_in_i;
            sync_r <= meta_r;
        end
    end

    // R16: crossbar on only with matrix enable set
    assign xbar_on = link.peripheral_select_1[`PCPA_S1_XBARON];

    // resource enables in priority order
    always_comb begin
        res_en             = 17'h00000;
        res_en[pcpa_pkg::RES_TX]   = link.peripheral_select_0[`PCPA_S0_UART];
        res_en[pcpa_pkg::RES_RX]   = link.peripheral_select_0[`PCPA_S0_UART];
        res_en[pcpa_pkg::RES_SCK]  = link.peripheral_select_0[`PCPA_S0_SPI];
        res_en[pcpa_pkg::RES_MISO] = link.peripheral_select_0[`PCPA_S0_SPI];
        res_en[pcpa_pkg::RES_MOSI] = link.peripheral_select_0[`PCPA_S0_SPI];
        // R13: slave select only in four-wire mode
        res_en[pcpa_pkg::RES_NSEL] = link.peripheral_select_0[`PCPA_S0_SPI]
                                   & link.peripheral_select_0[`PCPA_S0_SPI4W];
        res_en[pcpa_pkg::RES_SDA]  = link.peripheral_select_0[`PCPA_S0_SMB];
        res_en[pcpa_pkg::RES_SCL]  = link.peripheral_select_0[`PCPA_S0_SMB];
        res_en[pcpa_pkg::RES_CMP]  = link.peripheral_select_0[`PCPA_S0_CMP];
        res_en[pcpa_pkg::RES_CMPA] = link.peripheral_select_0[`PCPA_S0_CMPA];
        res_en[pcpa_pkg::RES_CLKOUT] = link.peripheral_select_0[`PCPA_S0_CLKOUT];
        res_en[pcpa_pkg::RES_CHAN0] = |link.peripheral_select_1[`PCPA_S1_PCA_HI:`PCPA_S1_PCA_LO];
        res_en[pcpa_pkg::RES_CHAN1] = link.peripheral_select_1[`PCPA_S1_PCA_HI];
        res_en[pcpa_pkg::RES_CHAN2] = &link.peripheral_select_1[`PCPA_S1_PCA_HI:`PCPA_S1_PCA_LO];
        res_en[pcpa_pkg::RES_ECLK] = link.peripheral_select_1[`PCPA_S1_EXTCLK];
        res_en[pcpa_pkg::RES_TMR0] = link.peripheral_select_1[`PCPA_S1_TMR0];
        res_en[pcpa_pkg::RES_TMR1] = link.peripheral_select_1[`PCPA_S1_TMR1];
    end

    // placement walk; special-function signals have no entry here at all
    // R09: analog and oscillator pins are only reserved through skip bits
    always_comb begin
        logic [5:0] hit;
        hit      = 6'h00;
        place_ok = 17'h00000;
        // R06: skipped pins start out as taken
        used     = link.pin_skip_bits;
        for (int r = 0; r < `PCPA_RES; r++) begin
            place_idx[r] = 5'h00;
        end
        // R02: serial port placed before anything else
        // R04: serial pins fixed, regardless of skip bits
        if (res_en[pcpa_pkg::RES_TX]) begin
            place_idx[pcpa_pkg::RES_TX] = `PCPA_UART_TX_PIN;
            place_idx[pcpa_pkg::RES_RX] = `PCPA_UART_RX_PIN;
            place_ok[pcpa_pkg::RES_TX]  = 1'b1;
            place_ok[pcpa_pkg::RES_RX]  = 1'b1;
            used[`PCPA_UART_TX_PIN]     = 1'b1;
            used[`PCPA_UART_RX_PIN]     = 1'b1;
        end
        // R03: remaining resources walked in enum order
        for (int r = pcpa_pkg::RES_SCK; r < `PCPA_RES; r++) begin
            if (res_en[r]) begin
                // R01: lowest free pin; R07: limited to crossbar range
                hit = first_free(used);
                place_ok[r]  = hit[5];
                place_idx[r] = hit[4:0];
                // R05: claimed pin is passed over afterwards
                if (hit[5]) begin
                    used[hit[4:0]] = 1'b1;
                end
            end
        end
    end

    // placement held in flops; claimed map reported to the controller
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            ok_r      <= 17'h00000;
            claimed_r <= 21'h000000;
            for (int r = 0; r < `PCPA_RES; r++) begin
                idx_r[r] <= 5'h00;
            end
        end else begin
            ok_r      <= xbar_on ? place_ok : 17'h00000;
            claimed_r <= 21'h000000;
            for (int r = 0; r < `PCPA_RES; r++) begin
                idx_r[r] <= place_idx[r];
                if (xbar_on && place_ok[r]) begin
                    claimed_r[place_idx[r]] <= 1'b1;
                end
            end
        end
    end

    // pin drive: gpio on unclaimed pins, resources on claimed ones
    always_comb begin
        out_nxt = 21'h000000;
        oe_nxt  = 21'h000000;
        in_nxt  = 17'h1ffff;
        // R08: every pin in the gpio range may be driven as gpio
        for (int p = 0; p < GPIO_PINS; p++) begin
            out_nxt[p] = link.gpio_out[p];
            oe_nxt[p]  = link.gpio_oe[p] & ~claimed_r[p];
        end
        for (int r = 0; r < `PCPA_RES; r++) begin
            if (ok_r[r]) begin
                out_nxt[idx_r[r]] = periph_out_i[r];
                oe_nxt[idx_r[r]]  = periph_oe_i[r];
                in_nxt[r]         = sync_r[idx_r[r]];
            end
        end
        // R17: disabled crossbar leaves every pin an input
        // R18: drivers off, gpio output included
        if (!xbar_on) begin
            oe_nxt = 21'h000000;
        end
    end

    // registered pin and peripheral outputs; one cycle behind the map
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            pin_out_o   <= 21'h000000;
            pin_oe_o    <= 21'h000000;
            periph_in_o <= 17'h1ffff;
        end else begin
            pin_out_o   <= out_nxt;
            pin_oe_o    <= oe_nxt;
            periph_in_o <= in_nxt;
        end
    end

    assign link.pin_state   = sync_r;
    assign link.pin_claimed = claimed_r;
endmodule

// >>> common/pcpa_consts.svh
// offsets, field positions, reset values and sizes of the pin assigner
`ifndef PCPA_CONSTS_SVH
`define PCPA_CONSTS_SVH

// register byte offsets on the controller bus
`define PCPA_OFS_SKIP      8'h00
`define PCPA_OFS_SEL0      8'h04
`define PCPA_OFS_SEL1      8'h08
`define PCPA_OFS_GPIO_OUT  8'h0c
`define PCPA_OFS_GPIO_OE   8'h10
`define PCPA_OFS_PIN_IN    8'h14
`define PCPA_OFS_CLAIMED   8'h18

// peripheral_select_0 field positions
`define PCPA_S0_UART       0
`define PCPA_S0_SPI        1
`define PCPA_S0_SPI4W      2
`define PCPA_S0_SMB        3
`define PCPA_S0_CMP        4
`define PCPA_S0_CMPA       5
`define PCPA_S0_CLKOUT     6
`define PCPA_S0_W          7

// peripheral_select_1 field positions
`define PCPA_S1_PCA_LO     0
`define PCPA_S1_PCA_HI     1
`define PCPA_S1_EXTCLK     2
`define PCPA_S1_TMR0       3
`define PCPA_S1_TMR1       4
`define PCPA_S1_XBARON     6
`define PCPA_S1_W          7

// reset values
`define PCPA_RST_SKIP      21'h000000
`define PCPA_RST_SEL0      7'h00
`define PCPA_RST_SEL1      7'h00
`define PCPA_RST_GPIO      21'h000000

// pin counts and fixed serial pins
`define PCPA_PINS          21
`define PCPA_XBAR_LARGE    20
`define PCPA_XBAR_SMALL    16
`define PCPA_GPIO_SMALL    17
`define PCPA_RES           17
`define PCPA_UART_TX_PIN   5'h04
`define PCPA_UART_RX_PIN   5'h05

`endif

// >>> common/pcpa_pkg.sv
// types of the pin assigner, used by the crossbar decoder
package pcpa_pkg;
    typedef logic [20:0] pcpa_pins_t;
    typedef logic [4:0]  pcpa_idx_t;
    // resources in decoder priority order, first is highest
    typedef enum logic [4:0] {
        RES_TX, RES_RX, RES_SCK, RES_MISO, RES_MOSI, RES_NSEL, RES_SDA, RES_SCL,
        RES_CMP, RES_CMPA, RES_CLKOUT, RES_CHAN0, RES_CHAN1, RES_CHAN2, RES_ECLK,
        RES_TMR0, RES_TMR1
    } pcpa_res_e;
endpackage

// >>> common/pcpa_if.sv
// link between the register controller and the crossbar decoder
`timescale 1ns/10ps
interface pcpa_if;
    logic [20:0] pin_skip_bits;
    logic [6:0]  peripheral_select_0;
    logic [6:0]  peripheral_select_1;
    logic [20:0] gpio_out;
    logic [20:0] gpio_oe;
    logic [20:0] pin_state;
    logic [20:0] pin_claimed;

    modport dev (
        input  pin_skip_bits,
        input  peripheral_select_0,
        input  peripheral_select_1,
        input  gpio_out,
        input  gpio_oe,
        output pin_state,
        output pin_claimed
    );
    modport ctl (
        output pin_skip_bits,
        output peripheral_select_0,
        output peripheral_select_1,
        output gpio_out,
        output gpio_oe,
        input  pin_state,
        input  pin_claimed
    );
endinterface

// >>> design/pcpa_ctl.sv
// register controller: ahb-lite slave holding skip, select and gpio registers
`timescale 1ns/10ps
`include "pcpa_consts.svh"
module pcpa_ctl (
    input  wire logic        clock_i,
    input  wire logic        sys_rst_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic [31:0]      hrdata_o,
    pcpa_if.ctl              link
);
    logic [20:0] skip_r;
    logic [6:0]  sel0_r;
    logic [6:0]  sel1_r;
    logic [20:0] gout_r;
    logic [20:0] goe_r;
    logic        wr_pend_r;
    logic [7:0]  wr_addr_r;
    logic        take;

    // only single word transfers; hsize is accepted but not checked
    assign take        = hsel_i && htrans_i[1] && hready_i;
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;

    // address phase capture for writes
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else begin
            wr_pend_r <= take && hwrite_i;
            wr_addr_r <= haddr_i[7:0];
        end
    end

    // data phase write; unmapped offsets are dropped
    // R10: software reserves analog pins by setting skip bits here
    // R16: matrix enable lives in select 1
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            skip_r <= `PCPA_RST_SKIP;
            sel0_r <= `PCPA_RST_SEL0;
            sel1_r <= `PCPA_RST_SEL1;
            gout_r <= `PCPA_RST_GPIO;
            goe_r  <= `PCPA_RST_GPIO;
        end else if (wr_pend_r) begin
            case (wr_addr_r)
                `PCPA_OFS_SKIP:     skip_r <= hwdata_i[20:0];
                `PCPA_OFS_SEL0:     sel0_r <= hwdata_i[6:0];
                `PCPA_OFS_SEL1:     sel1_r <= hwdata_i[6:0];
                `PCPA_OFS_GPIO_OUT: gout_r <= hwdata_i[20:0];
                `PCPA_OFS_GPIO_OE:  goe_r  <= hwdata_i[20:0];
                default: ;
            endcase
        end
    end

    // read data prepared at the address phase, so zero wait states
    // a read right after a write to the same register sees the old value
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            hrdata_o <= 32'h00000000;
        end else if (take && !hwrite_i) begin
            case (haddr_i[7:0])
                `PCPA_OFS_SKIP:     hrdata_o <= {11'h000, skip_r};
                `PCPA_OFS_SEL0:     hrdata_o <= {25'h0000000, sel0_r};
                `PCPA_OFS_SEL1:     hrdata_o <= {25'h0000000, sel1_r};
                `PCPA_OFS_GPIO_OUT: hrdata_o <= {11'h000, gout_r};
                `PCPA_OFS_GPIO_OE:  hrdata_o <= {11'h000, goe_r};
                `PCPA_OFS_PIN_IN:   hrdata_o <= {11'h000, link.pin_state};
                `PCPA_OFS_CLAIMED:  hrdata_o <= {11'h000, link.pin_claimed};
                default:            hrdata_o <= 32'h00000000;
            endcase
        end
    end

    // R11: gpio pins are skipped by software through the same register
    assign link.pin_skip_bits       = skip_r;
    assign link.peripheral_select_0 = sel0_r;
    assign link.peripheral_select_1 = sel1_r;
    assign link.gpio_out            = gout_r;
    assign link.gpio_oe             = goe_r;
endmodule

// >>> verif/pcpa_assertions.sv
// concurrent checks on the link between controller and decoder
`timescale 1ns/10ps
module pcpa_assertions (
    input wire logic        clock_i,
    input wire logic        sys_rst_i,
    input wire logic [20:0] pin_skip_bits,
    input wire logic [6:0]  peripheral_select_0,
    input wire logic [6:0]  peripheral_select_1,
    input wire logic [20:0] gpio_out,
    input wire logic [20:0] gpio_oe,
    input wire logic [20:0] pin_state,
    input wire logic [20:0] pin_claimed
);
    // one clock domain, so clock and reset are given once
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    a_off_no_claim: assert property (!peripheral_select_1[6] |=> pin_claimed == 21'h000000)
        else $error("pins claimed while matrix is off");
    a_uart_fixed: assert property (peripheral_select_1[6] && peripheral_select_0[0]
        |=> pin_claimed[5:4] == 2'b11)
        else $error("serial port pins not claimed");
    // serial pins 4 and 5 are exempt, they are placed even when skipped
    a_skip_kept: assert property (peripheral_select_1[6] |=>
        (pin_claimed & $past(pin_skip_bits) & 21'h1fffcf) == 21'h000000)
        else $error("skipped pin was claimed");
    a_top_free: assert property (pin_claimed[20] == 1'b0)
        else $error("pin above crossbar range claimed");
    a_claim_steady: assert property ($stable(pin_skip_bits) && $stable(peripheral_select_0)
        && $stable(peripheral_select_1) |=> $stable(pin_claimed))
        else $error("placement moved with steady config");
    a_spi_three: assert property (peripheral_select_1 == 7'h40 && peripheral_select_0 == 7'h02
        && pin_skip_bits == 21'h000000 |=> pin_claimed == 21'h000007)
        else $error("three-wire sync port placement wrong");
    a_spi_four: assert property (peripheral_select_1 == 7'h40 && peripheral_select_0 == 7'h06
        && pin_skip_bits == 21'h000000 |=> pin_claimed == 21'h00000f)
        else $error("four-wire sync port placement wrong");
    a_idle_free: assert property (peripheral_select_1 == 7'h40 && peripheral_select_0 == 7'h00
        |=> pin_claimed == 21'h000000)
        else $error("pin claimed with nothing selected");
endmodule

// >>> verif/pcpa_bench.sv
// self-checking bench: controller and decoder joined through the link
`timescale 1ns/10ps
`include "pcpa_consts.svh"
module pcpa_bench;
    logic        clock_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        hsel, hwrite, hready, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [16:0] p_out, p_oe, p_in;
    logic [20:0] pin_in, pin_out, pin_oe;
    logic [20:0] exp_claim;
    int          pin_of [17];
    int          fails = 0;
    int          check_count = 0;

    pcpa_if link ();
    pcpa_ctl i_pcpa_ctl (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata), .hready_i(hready),
        .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata), .link(link));
    pcpa_xbar #(.LARGE_PKG(1'b1)) i_pcpa_xbar (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .link(link),
        .periph_out_i(p_out), .periph_oe_i(p_oe), .periph_in_o(p_in), .pin_in_i(pin_in),
        .pin_out_o(pin_out), .pin_oe_o(pin_oe));
    pcpa_assertions i_pcpa_assertions (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .pin_skip_bits(link.pin_skip_bits), .peripheral_select_0(link.peripheral_select_0),
        .peripheral_select_1(link.peripheral_select_1), .gpio_out(link.gpio_out), .gpio_oe(link.gpio_oe),
        .pin_state(link.pin_state), .pin_claimed(link.pin_claimed));

    // 25 MHz system clock
    always #20 clock_i = ~clock_i;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // single transfer; waits on hready, no fixed latency assumed
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clock_i); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clock_i); while (hready !== 1'b1);
        r = hrdata;
        chk(hresp, 1'b0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(a, 1'b1, d, r);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(a, 1'b0, 32'h00000000, r);
        chk(r, exp);
    endtask

    // reference placement: priority walk, lowest free pin first
    task automatic place_check(input logic [20:0] skip, input logic [6:0] s0, input logic [6:0] s1,
                               input logic [20:0] goe);
        logic [16:0] en;
        logic [20:0] used;
        logic [20:0] eoe;
        logic [16:0] ein;
        logic [20:0] eout;
        en = {s1[4], s1[3], s1[2], s1[1:0] > 2'd2, s1[1:0] > 2'd1, s1[1:0] > 2'd0, s0[6], s0[5], s0[4],
              s0[3], s0[3], s0[1] & s0[2], {3{s0[1]}}, {2{s0[0]}}};
        wr(`PCPA_OFS_GPIO_OE, {11'h000, goe});
        wr(`PCPA_OFS_SKIP, {11'h000, skip});
        wr(`PCPA_OFS_SEL0, {25'h0000000, s0});
        wr(`PCPA_OFS_SEL1, {25'h0000000, s1});
        exp_claim = {15'h0000, s0[0], s0[0], 4'h0};
        used = skip | exp_claim;
        pin_of[0] = s0[0] ? 4 : -1;
        pin_of[1] = s0[0] ? 5 : -1;
        for (int r = 2; r < 17; r++) begin
            pin_of[r] = -1;
            // crossbar range ends below pin 20
            for (int p = 0; p < 20; p++) begin
                if (en[r] && !used[p] && pin_of[r] < 0) begin
                    pin_of[r] = p;
                    used[p] = 1'b1;
                    exp_claim[p] = 1'b1;
                end
            end
        end
        eoe = goe & ~exp_claim;
        ein = 17'h1ffff;
        eout = 21'h000000;
        for (int r = 0; r < 17; r++) begin
            if (pin_of[r] >= 0) begin
                ein[r] = pin_in[pin_of[r]];
                eout[pin_of[r]] = p_out[r];
                eoe[pin_of[r]] = p_oe[r];
            end
        end
        repeat (3) @(posedge clock_i);
        rdc(`PCPA_OFS_CLAIMED, {11'h000, exp_claim});
        chk(p_in, ein);
        chk(pin_oe, eoe);
        chk(pin_out & exp_claim, eout);
    endtask

    task automatic t_regs();
        rdc(`PCPA_OFS_SKIP, 32'h00000000);
        rdc(`PCPA_OFS_SEL0, 32'h00000000);
        wr(`PCPA_OFS_SKIP, 32'hffffffff);
        rdc(`PCPA_OFS_SKIP, 32'h001fffff);
        wr(8'h1c, 32'hffffffff);
        rdc(8'h1c, 32'h00000000);
        wr(`PCPA_OFS_SKIP, 32'h00000000);
        wr(`PCPA_OFS_SEL1, 32'h00000040);
        rdc(`PCPA_OFS_SEL1, 32'h00000040);
        $display("t_regs done");
    endtask

    // matrix off: gpio and serial asked for, yet nothing may drive
    task automatic t_off();
        wr(`PCPA_OFS_GPIO_OUT, 32'h001fffff);
        wr(`PCPA_OFS_GPIO_OE, 32'h001fffff);
        wr(`PCPA_OFS_SEL0, 32'h00000001);
        wr(`PCPA_OFS_SEL1, 32'h0000001f);
        repeat (3) @(posedge clock_i);
        chk(pin_oe, 21'h000000);
        chk(p_in, 17'h1ffff);
        rdc(`PCPA_OFS_CLAIMED, 32'h00000000);
        rdc(`PCPA_OFS_PIN_IN, {11'h000, pin_in});
        $display("t_off done");
    endtask

    // reference pin 0 skipped as software would
    task automatic t_uart();
        place_check(21'h000031, 7'h01, 7'h40, 21'h000000);
        $display("t_uart done");
    endtask

    task automatic t_full();
        place_check(21'h000003, 7'h7f, 7'h5f, 21'h000000);
        $display("t_full done");
    endtask

    task automatic t_spi();
        place_check(21'h000000, 7'h02, 7'h40, 21'h000000);
        place_check(21'h000000, 7'h06, 7'h40, 21'h000000);
        $display("t_spi done");
    endtask

    // pins run out; the top pin stays plain gpio
    // analog pins reserved through skip bits
    // gpio pins skipped, left to software
    task automatic t_exhaust();
        place_check(21'h00ffcf, 7'h7f, 7'h5f, 21'h100000);
        chk(pin_out[20], 1'b1);
        $display("t_exhaust done");
    endtask

    task automatic wrap_up();
        $display("checks=%0d fails=%0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // reset for 10 cycles, then the scenarios in turn
    initial begin
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h00000000;
        p_out = 17'h15a5a;
        p_oe = 17'h0c3c3;
        pin_in = 21'h1a6c35;
        repeat (10) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        @(posedge clock_i);
        t_regs();
        t_off();
        t_uart();
        t_full();
        t_spi();
        t_exhaust();
        wrap_up();
    end

    // watchdog: the whole run needs well under 1000 cycles
    initial begin
        repeat (4000) @(posedge clock_i);
        fails++;
        wrap_up();
    end
endmodule
